/* rtl/instruction_subset_exec.sv */
// Top of the instruction subset execution block with its AXI4-Lite register slave
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "exec_defines.svh"

// Overview of operation
// - Sleep clears power-down flag, sets expiry flag, other status untouched.
// - Sleep zeroes the watchdog counter and its prescaler.
// - Sleep enters low-power state with the oscillator stopped.
// - Subroutine exit pops the stack into the program counter, flags untouched.
// - Subroutine exit takes two instruction cycles.
// - Literal subtract: immediate minus accumulator into accumulator, C DC Z updated.
// - Register subtract: file minus accumulator to destination, C DC Z updated.
// - Rotate right through carry; only carry changes.
// - Nibble exchange swaps halves of the file register; no flags change.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Register XOR to destination, only zero flag updated.
// - Literal XOR into accumulator, only zero flag updated.
// - File address is seven bits, locations 0 to 127.
module instruction_subset_exec
#(
  parameter int FILE_DEPTH  = 128,
  parameter int STACK_DEPTH = 8,
  parameter int PC_WIDTH    = 13
)
(
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                wake_i,
  output logic                     osc_stop_o,
  output logic                     wdt_clear_o,
  output logic [PC_WIDTH-1:0]      pc_o
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed
  {
    exec_pkg::exec_state_t state;
    logic [7:0]            acc;
    logic                  c;
    logic                  dc;
    logic                  z;
    logic                  pd_n;
    logic                  to_n;
    logic [7:0]            operand;
    logic [PC_WIDTH-1:0]   pc;
    logic [7:0]            wdt;
    logic [7:0]            psc;
    logic                  wdt_clr;
    logic                  aw_held;
    logic [7:0]            aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } regs_t;

  regs_t      cur_reg;
  regs_t      cur_next;
  logic [7:0] file_mem [FILE_DEPTH];

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  function automatic logic is_file(input logic [7:0] a);
    is_file = a[`ADDR_FILE_SEL];
  endfunction

  function automatic logic [6:0] file_idx(input logic [7:0] a);
    file_idx = a[6:0];
  endfunction

  // --------------------------------------------------------------------------
  // Datapath
  // --------------------------------------------------------------------------
  exec_pkg::op_t       op;
  logic                dest_file;
  logic [6:0]          faddr;
  logic [7:0]          file_val;
  logic [7:0]          alu_opnd;
  logic [7:0]          alu_res;
  logic                alu_c;
  logic                alu_dc;
  logic                upd_c;
  logic                upd_dc;
  logic                upd_z;
  logic [PC_WIDTH-1:0] stack_top;
  logic                do_write;
  logic                cmd_go;
  logic                stack_push;
  logic                stack_pop;
  logic                file_we;
  logic [6:0]          file_wa;
  logic [7:0]          file_wd;

  assign do_write  = cur_reg.aw_held && cur_reg.w_held && !cur_reg.bvalid;
  assign cmd_go    = do_write && (cur_reg.aw_addr == `ADDR_CMD) && cur_reg.w_strb[0]
                     && (cur_reg.state == exec_pkg::ST_IDLE);
  assign op        = exec_pkg::op_t'(cur_reg.w_data[`CMD_OP_MSB:`CMD_OP_LSB]);
  assign dest_file = cur_reg.w_data[`CMD_DEST_BIT];
  assign faddr     = cur_reg.operand[`OPND_FADDR_MSB:`OPND_LSB];
  assign file_val  = file_mem[faddr];
  assign alu_opnd  = (op == exec_pkg::OP_LIT_SUB || op == exec_pkg::OP_LIT_XOR) ? cur_reg.operand : file_val;
  assign stack_push = do_write && (cur_reg.aw_addr == `ADDR_STACK_PUSH);
  assign stack_pop  = cmd_go && (op == exec_pkg::OP_RETURN);

  alu_core u_alu
  (
    .op_i         (cmd_go ? op : exec_pkg::OP_NONE),
    .acc_i        (cur_reg.acc),
    .opnd_i       (alu_opnd),
    .carry_i      (cur_reg.c),
    .result_o     (alu_res),
    .carry_o      (alu_c),
    .half_carry_o (alu_dc),
    .upd_c_o      (upd_c),
    .upd_dc_o     (upd_dc),
    .upd_z_o      (upd_z)
  );

  call_stack #(.DEPTH(STACK_DEPTH), .PC_WIDTH(PC_WIDTH)) u_stack
  (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .push_i      (stack_push),
    .push_data_i (cur_reg.w_data[PC_WIDTH-1:0]),
    .pop_i       (stack_pop),
    .top_o       (stack_top)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    cur_next         = cur_reg;
    cur_next.wdt_clr = 1'b0;
    file_we          = 1'b0;
    file_wa          = faddr;
    file_wd          = alu_res;
    // Watchdog counter advances only while awake; prescaler wraps into it
    if (cur_reg.state != exec_pkg::ST_SLEEP)
    begin
      cur_next.psc = cur_reg.psc + 8'h01;
      if (cur_reg.psc == 8'hFF)
        cur_next.wdt = cur_reg.wdt + 8'h01;
    end

    case (cur_reg.state)
      exec_pkg::ST_IDLE:
        if (cmd_go)
        begin
          case (op)
            exec_pkg::OP_SLEEP:
            begin
              cur_next.pd_n    = 1'b0;
              cur_next.to_n    = 1'b1;
              cur_next.wdt     = `WDT_CLEAR;
              cur_next.psc     = `PSC_CLEAR;
              cur_next.wdt_clr = 1'b1;
              cur_next.state   = exec_pkg::ST_SLEEP;
            end
            exec_pkg::OP_RETURN:
              cur_next.state = exec_pkg::ST_RET2;
            exec_pkg::OP_LIT_SUB, exec_pkg::OP_LIT_XOR:
              cur_next.acc = alu_res;
            exec_pkg::OP_REG_SUB, exec_pkg::OP_ROT_RIGHT, exec_pkg::OP_NIB_SWAP, exec_pkg::OP_REG_XOR:
              if (dest_file)
                file_we = 1'b1;
              else
                cur_next.acc = alu_res;
            default:
              cur_next.state = exec_pkg::ST_IDLE;
          endcase
          if (upd_c)
            cur_next.c = alu_c;
          if (upd_dc)
            cur_next.dc = alu_dc;
          if (upd_z)
            cur_next.z = (alu_res == `BYTE_ZERO);
        end
      exec_pkg::ST_RET2:
      begin
        // Pop and load were done on the first cycle; the stack top has moved on since
        cur_next.state = exec_pkg::ST_IDLE;
      end
      exec_pkg::ST_SLEEP:
        if (wake_i)
          cur_next.state = exec_pkg::ST_IDLE;
      default:
        cur_next.state = exec_pkg::ST_IDLE;
    endcase
    if (cmd_go && op == exec_pkg::OP_RETURN)
      cur_next.pc = stack_top;

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------------
    if (s_axi_awvalid && s_axi_awready)
    begin
      cur_next.aw_held = 1'b1;
      cur_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      cur_next.w_held = 1'b1;
      cur_next.w_data = s_axi_wdata;
      cur_next.w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      cur_next.aw_held = 1'b0;
      cur_next.w_held  = 1'b0;
      cur_next.bvalid  = 1'b1;
      cur_next.bresp   = `RESP_OKAY;
      case (cur_reg.aw_addr)
        `ADDR_CMD:
          if (cur_reg.state != exec_pkg::ST_IDLE)
            cur_next.bresp = `RESP_SLVERR;
        `ADDR_OPERAND:
          if (cur_reg.w_strb[0])
            cur_next.operand = cur_reg.w_data[`OPND_MSB:`OPND_LSB];
        `ADDR_ACC:
          if (cur_reg.w_strb[0])
            cur_next.acc = cur_reg.w_data[7:0];
        `ADDR_STATUS:
          if (cur_reg.w_strb[0])
          begin
            cur_next.c  = cur_reg.w_data[`STAT_C];
            cur_next.dc = cur_reg.w_data[`STAT_DC];
            cur_next.z  = cur_reg.w_data[`STAT_Z];
          end
        `ADDR_STACK_PUSH:
          cur_next.bresp = `RESP_OKAY;
        default:
          if (is_file(cur_reg.aw_addr))
          begin
            if (cur_reg.w_strb[0] && !cmd_go)
            begin
              file_we = 1'b1;
              file_wa = file_idx(cur_reg.aw_addr);
              file_wd = cur_reg.w_data[7:0];
            end
          end
          else
            cur_next.bresp = `RESP_SLVERR;
      endcase
    end
    if (cur_reg.bvalid && s_axi_bready)
      cur_next.bvalid = 1'b0;

    // ------------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------------
    if (s_axi_arvalid && s_axi_arready)
    begin
      cur_next.rvalid = 1'b1;
      cur_next.rresp  = `RESP_OKAY;
      cur_next.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        `ADDR_CMD:     cur_next.rdata = {29'h0, cur_reg.state};
        `ADDR_OPERAND: cur_next.rdata = {24'h0, cur_reg.operand};
        `ADDR_ACC:     cur_next.rdata = {24'h0, cur_reg.acc};
        `ADDR_STATUS:  cur_next.rdata = {25'h0, cur_reg.state != exec_pkg::ST_IDLE,
                                         cur_reg.state == exec_pkg::ST_SLEEP, cur_reg.to_n,
                                         cur_reg.pd_n, cur_reg.z, cur_reg.dc, cur_reg.c};
        `ADDR_PC:      cur_next.rdata = {{(32-PC_WIDTH){1'b0}}, cur_reg.pc};
        `ADDR_WDT:     cur_next.rdata = {16'h0, cur_reg.psc, cur_reg.wdt};
        default:
          if (is_file(s_axi_araddr))
            cur_next.rdata = {24'h0, file_mem[file_idx(s_axi_araddr)]};
          else
            cur_next.rresp = `RESP_SLVERR;
      endcase
    end
    if (cur_reg.rvalid && s_axi_rready)
      cur_next.rvalid = 1'b0;
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      cur_reg       <= '0;
      cur_reg.state <= exec_pkg::ST_IDLE;
      cur_reg.acc   <= `ACC_RESET;
      cur_reg.pd_n  <= 1'b1;
      cur_reg.to_n  <= 1'b1;
    end
    else
      cur_reg <= cur_next;
  end

  // File memory has no reset; contents are undefined until written
  always_ff @(posedge core_clk_i)
  begin
    if (file_we)
      file_mem[file_wa] <= file_wd;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign s_axi_awready = !cur_reg.aw_held && !cur_reg.bvalid;
  assign s_axi_wready  = !cur_reg.w_held && !cur_reg.bvalid;
  assign s_axi_bvalid  = cur_reg.bvalid;
  assign s_axi_bresp   = cur_reg.bresp;
  assign s_axi_arready = !cur_reg.rvalid;
  assign s_axi_rvalid  = cur_reg.rvalid;
  assign s_axi_rdata   = cur_reg.rdata;
  assign s_axi_rresp   = cur_reg.rresp;
  assign osc_stop_o    = (cur_reg.state == exec_pkg::ST_SLEEP);
  assign wdt_clear_o   = cur_reg.wdt_clr;
  assign pc_o          = cur_reg.pc;

endmodule // instruction_subset_exec

/* rtl/exec_defines.svh */
// Constants for the instruction subset execution block
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define ADDR_CMD        8'h00
`define ADDR_OPERAND    8'h04
`define ADDR_ACC        8'h08
`define ADDR_STATUS     8'h0C
`define ADDR_PC         8'h10
`define ADDR_WDT        8'h14
`define ADDR_STACK_PUSH 8'h18
`define ADDR_FILE_BASE  8'h80
`define ADDR_FILE_SEL   7

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CMD_OP_LSB      0
`define CMD_OP_MSB      3
`define CMD_DEST_BIT    4
`define OPND_LSB        0
`define OPND_MSB        7
`define OPND_FADDR_MSB  6
`define STAT_C          0
`define STAT_DC         1
`define STAT_Z          2
`define STAT_PD_N       3
`define STAT_TO_N       4
`define STAT_SLEEP      5
`define STAT_BUSY       6

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define ACC_RESET       8'h00
`define STATUS_RESET    5'h18
`define WDT_CLEAR       8'h00
`define PSC_CLEAR       8'h00
`define BYTE_ZERO       8'h00
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* rtl/exec_pkg.sv */
// Types for the instruction subset execution block
package exec_pkg;

  typedef enum logic [3:0]
  {
    OP_NONE       = 4'h0,
    OP_SLEEP      = 4'h1,
    OP_RETURN     = 4'h2,
    OP_LIT_SUB    = 4'h3,
    OP_REG_SUB    = 4'h4,
    OP_ROT_RIGHT  = 4'h5,
    OP_NIB_SWAP   = 4'h6,
    OP_REG_XOR    = 4'h7,
    OP_LIT_XOR    = 4'h8
  } op_t;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b001,
    ST_RET2   = 3'b010,
    ST_SLEEP  = 3'b100
  } exec_state_t;

endpackage

/* rtl/alu_core.sv */
// Combinational arithmetic unit for the instruction subset
`timescale 1ns/1ps
`include "exec_defines.svh"

module alu_core
(
  input  wire exec_pkg::op_t op_i,
  input  wire logic [7:0]    acc_i,
  input  wire logic [7:0]    opnd_i,
  input  wire logic          carry_i,
  output logic [7:0]         result_o,
  output logic               carry_o,
  output logic               half_carry_o,
  output logic               upd_c_o,
  output logic               upd_dc_o,
  output logic               upd_z_o
);

  logic [8:0] diff;
  logic [4:0] low_diff;

  // Borrow-inverted carries come free from a + ~b + 1
  assign diff     = {1'b0, opnd_i} + {1'b0, ~acc_i} + 9'h001;
  assign low_diff = {1'b0, opnd_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;

  always_comb
  begin
    result_o     = acc_i;
    carry_o      = carry_i;
    half_carry_o = 1'b0;
    upd_c_o      = 1'b0;
    upd_dc_o     = 1'b0;
    upd_z_o      = 1'b0;
    case (op_i)
      exec_pkg::OP_LIT_SUB, exec_pkg::OP_REG_SUB:
      begin
        result_o     = diff[7:0];
        carry_o      = diff[8];
        half_carry_o = low_diff[4];
        upd_c_o      = 1'b1;
        upd_dc_o     = 1'b1;
        upd_z_o      = 1'b1;
      end
      exec_pkg::OP_ROT_RIGHT:
      begin
        result_o = {carry_i, opnd_i[7:1]};
        carry_o  = opnd_i[0];
        upd_c_o  = 1'b1;
      end
      exec_pkg::OP_NIB_SWAP:
        result_o = {opnd_i[3:0], opnd_i[7:4]};
      exec_pkg::OP_REG_XOR, exec_pkg::OP_LIT_XOR:
      begin
        result_o = acc_i ^ opnd_i;
        upd_z_o  = 1'b1;
      end
      default:
        result_o = acc_i;
    endcase
  end

endmodule // alu_core

/* rtl/call_stack.sv */
// Hardware return-address stack, circular like the original core
`timescale 1ns/1ps

module call_stack
#(
  parameter int DEPTH    = 8,
  parameter int PC_WIDTH = 13
)
(
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                push_i,
  input  wire logic [PC_WIDTH-1:0] push_data_i,
  input  wire logic                pop_i,
  output logic [PC_WIDTH-1:0]      top_o
);

  localparam int PW = $clog2(DEPTH);

  logic [PC_WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]       ptr_reg;
  logic [PW-1:0]       top_idx;

  // Overflow wraps and overwrites the oldest entry; no error is flagged
  assign top_idx = ptr_reg - PW'(1);
  assign top_o   = mem_reg[top_idx];

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      ptr_reg <= '0;
    else if (push_i)
      ptr_reg <= ptr_reg + PW'(1);
    else if (pop_i)
      ptr_reg <= top_idx;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (push_i)
      mem_reg[ptr_reg] <= push_data_i;
  end

endmodule // call_stack

/* test/instruction_subset_exec_props.sv */
// Port-level assertions for the instruction subset execution block
`timescale 1ns/1ps
`include "exec_defines.svh"

module instruction_subset_exec_props
#(
  parameter int PC_WIDTH = 13
)
(
  input wire logic                core_clk_i,
  input wire logic                rst_n_i,
  input wire logic [7:0]          s_axi_awaddr,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic [31:0]         s_axi_wdata,
  input wire logic [3:0]          s_axi_wstrb,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic                wake_i,
  input wire logic                osc_stop_o,
  input wire logic                wdt_clear_o,
  input wire logic [PC_WIDTH-1:0] pc_o
);

  // ----
  // Last command write, judged when its response rises
  // ----
  logic [7:0] aw_q;
  logic [4:0] w_q;
  logic       cmd_sleep;
  logic       cmd_ret;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_q <= 8'h00;
      w_q  <= 5'h00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        w_q <= {s_axi_wstrb[0], s_axi_wdata[3:0]};
    end
  end

  assign cmd_sleep = (aw_q == `ADDR_CMD) && (w_q == {1'b1, exec_pkg::OP_SLEEP});
  assign cmd_ret   = (aw_q == `ADDR_CMD) && (w_q == {1'b1, exec_pkg::OP_RETURN});

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_B_AFTER_AW_W: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("no write response after address and data");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");
  AST_W_STALL: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data after address");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");
  AST_SLEEP_STOP: assert property ($rose(s_axi_bvalid) && cmd_sleep && s_axi_bresp == `RESP_OKAY |-> osc_stop_o)
    else $error("oscillator not stopped by sleep");
  AST_WDT_PULSE: assert property ($rose(s_axi_bvalid) && cmd_sleep && s_axi_bresp == `RESP_OKAY |-> ##[0:1] wdt_clear_o)
    else $error("watchdog not cleared by sleep");
  AST_WDT_ONE: assert property (wdt_clear_o |=> !wdt_clear_o)
    else $error("watchdog clear longer than one cycle");
  AST_OSC_HOLD: assert property (osc_stop_o && !wake_i |=> osc_stop_o)
    else $error("sleep left without wake");
  AST_WAKE: assert property (osc_stop_o && wake_i |-> ##[1:2] !osc_stop_o)
    else $error("wake did not restart oscillator");
  AST_PC_ONLY_RET: assert property (!($rose(s_axi_bvalid) && cmd_ret) |-> $stable(pc_o))
    else $error("program counter moved without return");

  COV_SLEEP: cover property ($rose(osc_stop_o));
  COV_RET: cover property ($rose(s_axi_bvalid) && cmd_ret);
  COV_ERR: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);

endmodule // instruction_subset_exec_props

bind instruction_subset_exec instruction_subset_exec_props #(.PC_WIDTH(PC_WIDTH)) u_instruction_subset_exec_props
(
  .core_clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wake_i, .osc_stop_o, .wdt_clear_o, .pc_o
);

/* test/instruction_subset_exec_tb.sv */
// Self-checking testbench for the instruction subset execution block
`timescale 1ns/1ps
`include "exec_defines.svh"

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module instruction_subset_exec_tb;
  logic        core_clk_i    = 1'b0;
  logic        rst_n_i       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h00000000;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        wake_i        = 1'b0;
  logic        s_axi_awready;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        osc_stop_o;
  logic        wdt_clear_o;
  logic [12:0] pc_o;
  logic [1:0]  resp;
  int          err_total     = 0;
  int          checks_done   = 0;
  int          cycles        = 0;

  instruction_subset_exec u_instruction_subset_exec
  (
    .core_clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wake_i, .osc_stop_o,
    .wdt_clear_o, .pc_o
  );

  always #2.5 core_clk_i = ~core_clk_i;

  // ----
  // Closing report and hang guard
  // ----
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  // ----
  // AXI4-Lite master; readies and responses are read before this edge's updates land
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done = 1'b0;
    logic w_done = 1'b0;
    @(posedge core_clk_i);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever
    begin
      @(posedge core_clk_i);
      if (!aw_done && s_axi_awready)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    `CHK(r, `RESP_OKAY)
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_r);
    @(posedge core_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever
    begin
      @(posedge core_clk_i);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, exp)
        `CHK(s_axi_rresp, exp_r)
        break;
      end
    end
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    `CHK(osc_stop_o, 1'b0)
    `CHK(pc_o, 13'h0000)
    rd_chk(`ADDR_ACC, 32'h00000000, `RESP_OKAY);
    rd_chk(`ADDR_STATUS, 32'h00000018, `RESP_OKAY);
    rd_chk(`ADDR_CMD, 32'h00000001, `RESP_OKAY);
    rd_chk(8'h1C, 32'h00000000, `RESP_SLVERR);
    wr(8'h1C, 32'h00000000, resp);
    `CHK(resp, `RESP_SLVERR)
  endtask

  // Flags are {z, dc, c}; literal forms keep their file word at a fixed aligned spot
  task automatic run_op(input logic [3:0] op, input logic dst, input logic [7:0] opnd,
                        input logic [7:0] acc, input logic [7:0] fv, input logic [2:0] fl);
    logic       lit   = (op == 4'h3) || (op == 4'h8);
    logic [7:0] src   = lit ? opnd : fv;
    logic [7:0] faddr = lit ? 8'h84 : {1'b1, opnd[6:0]};
    logic [7:0] res;
    logic [2:0] nf    = fl;
    logic [7:0] facc  = acc;
    logic [7:0] ffile = fv;
    wr_ok(`ADDR_STATUS, {29'h00000000, fl});
    wr_ok(`ADDR_ACC, {24'h000000, acc});
    wr_ok(faddr, {24'h000000, fv});
    wr_ok(`ADDR_OPERAND, {24'h000000, opnd});
    wr_ok(`ADDR_CMD, {27'h0000000, dst, op});
    case (op)
      4'h3, 4'h4:
      begin
        res = src - acc;
        nf  = {res == 8'h00, src[3:0] >= acc[3:0], src >= acc};
      end
      4'h5:
      begin
        res   = {fl[0], fv[7:1]};
        nf[0] = fv[0];
      end
      4'h6: res = {fv[3:0], fv[7:4]};
      default:
      begin
        res   = acc ^ src;
        nf[2] = (res == 8'h00);
      end
    endcase
    if (dst && !lit)
      ffile = res;
    else
      facc = res;
    rd_chk(`ADDR_ACC, {24'h000000, facc}, `RESP_OKAY);
    rd_chk(faddr, {24'h000000, ffile}, `RESP_OKAY);
    rd_chk(`ADDR_STATUS, {27'h0000000, 2'b11, nf}, `RESP_OKAY);
  endtask

  task automatic t_ops();
    run_op(4'h3, 1'b0, 8'h05, 8'h05, 8'h00, 3'b000);
    run_op(4'h3, 1'b1, 8'h10, 8'h01, 8'h00, 3'b111);
    run_op(4'h3, 1'b0, 8'h00, 8'h01, 8'h00, 3'b111);
    run_op(4'h4, 1'b1, 8'h7C, 8'h2F, 8'hF0, 3'b000);
    run_op(4'h4, 1'b0, 8'hFC, 8'h01, 8'h01, 3'b000);
    run_op(4'h5, 1'b1, 8'h40, 8'h00, 8'h81, 3'b110);
    run_op(4'h5, 1'b0, 8'h20, 8'h00, 8'h80, 3'b001);
    run_op(4'h6, 1'b1, 8'h7C, 8'h00, 8'hA5, 3'b111);
    run_op(4'h6, 1'b0, 8'h04, 8'h55, 8'h3C, 3'b000);
    run_op(4'h7, 1'b1, 8'h08, 8'h5A, 8'h5A, 3'b011);
    run_op(4'h7, 1'b0, 8'h88, 8'hF0, 8'h0F, 3'b111);
    run_op(4'h8, 1'b1, 8'hFF, 8'hFF, 8'h00, 3'b011);
    run_op(4'h8, 1'b0, 8'h0F, 8'h3C, 8'h00, 3'b100);
  endtask

  task automatic t_ret();
    wr_ok(`ADDR_STATUS, 32'h00000005);
    wr_ok(`ADDR_STACK_PUSH, 32'h00000123);
    wr_ok(`ADDR_STACK_PUSH, 32'h00001ABC);
    `CHK(pc_o, 13'h0000)
    wr_ok(`ADDR_CMD, 32'h00000002);
    `CHK(pc_o, 13'h1ABC)
    rd_chk(`ADDR_PC, 32'h00001ABC, `RESP_OKAY);
    wr_ok(`ADDR_CMD, 32'h00000002);
    `CHK(pc_o, 13'h0123)
    rd_chk(`ADDR_STATUS, 32'h0000001D, `RESP_OKAY);
  endtask

  task automatic t_sleep();
    // Idle long enough that the watchdog has moved off zero before it is cleared
    repeat (300) @(posedge core_clk_i);
    wr_ok(`ADDR_STATUS, 32'h00000005);
    wr_ok(`ADDR_CMD, 32'h00000001);
    `CHK(osc_stop_o, 1'b1)
    rd_chk(`ADDR_WDT, 32'h00000000, `RESP_OKAY);
    rd_chk(`ADDR_STATUS, 32'h00000075, `RESP_OKAY);
    wr(`ADDR_CMD, 32'h00000008, resp);
    `CHK(resp, `RESP_SLVERR)
    rd_chk(`ADDR_ACC, 32'h00000033, `RESP_OKAY);
    @(posedge core_clk_i);
    wake_i <= 1'b1;
    @(posedge core_clk_i);
    wake_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    `CHK(osc_stop_o, 1'b0)
    rd_chk(`ADDR_STATUS, 32'h00000015, `RESP_OKAY);
  endtask

  initial
  begin
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_ops();
    t_ret();
    t_sleep();
    summarize();
  end

endmodule // instruction_subset_exec_tb
